// >>> rtl/nim_defs.svh
// Offsets, field positions, reset values and fixed masks of the interrupt block.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef NIM_DEFS_SVH
`define NIM_DEFS_SVH

`define NIM_OFS_MASK 8'h00
`define NIM_OFS_RSVD 8'h04
`define NIM_OFS_EVT 8'h08
`define NIM_OFS_THR 8'h0C

`define NIM_BIT_MEN 7
`define NIM_BIT_GSEL 16
`define NIM_EV_TXE 1
`define NIM_EV_TXW 2
`define NIM_EV_TXD 3
`define NIM_EV_RXF 11
`define NIM_EV_RXD 12
`define NIM_EV_PHY 13
`define NIM_EV_WAKE 14
`define NIM_EV_UP0 17
`define NIM_EV_TM0 19

`define NIM_MASK_RW 32'h0000788E
`define NIM_MASK_GRP 32'h001E0000
`define NIM_EVT_USED 32'h001E780E
`define NIM_MASK_RST 32'h00000000
`define NIM_EVT_RST 32'h00000000
`define NIM_THR_RST 16'h0000

`endif

// >>> rtl/nim_pkg.sv
// Types of the interrupt mask and event status block.
// Assumes nim_defs.svh supplies the numbers.
package nim_pkg;

    // Whole state of the block, one register set
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [31:0] mask;
        logic [31:0] ev;
        logic [15:0] thr;
        logic [1:0] up_s1;
        logic [1:0] up_s2;
        logic [1:0] up_p;
        logic [31:0] phy_s1;
        logic [31:0] phy_s2;
        logic [31:0] phy_p;
        logic [2:0] phy_ok;
        logic txc_busy;
        logic txr_q;
        logic [1:0] tm_p;
        logic dma_pend;
    } nim_state_s;

endpackage : nim_pkg

// >>> rtl/nim_irq.sv
// Interrupt mask, event status and level interrupt of the network controller.
// Assumes a classic Wishbone master on clk_sys; event pulses come from the
// same clock, user pins and PHY status come from outside and are synchronised.
//
// The Wishbone slave port and the placing of the registers were decided locally.
`include "nim_defs.svh"

module nim_irq #(
    parameter int ADR_W = 8,
    parameter int PHY_W = 8,
    parameter int TMR_W = 16,
    parameter int CNT_W = 8,
    parameter int LVL_W = 16
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rx_frame_stored,
    input wire logic rx_xfer_done,
    input wire logic rx_desc_irq_flag,
    input wire logic [PHY_W-1:0] phy_status,
    input wire logic wake_frame_seen,
    input wire logic [1:0] user_input,
    input wire logic [TMR_W-1:0] timer0_count,
    input wire logic [TMR_W-1:0] timer0_trigger,
    input wire logic [TMR_W-1:0] timer1_count,
    input wire logic [TMR_W-1:0] timer1_trigger,
    input wire logic [CNT_W-1:0] tx_cmd_count,
    input wire logic tx_fifo_rd,
    input wire logic [LVL_W-1:0] tx_fifo_level,
    input wire logic tx_frame_fetched,
    input wire logic tx_frame_last,
    input wire logic dma_done_irq_request_flag,
    output logic irq
);

    // Refuse widths the 32-bit and 16-bit state fields cannot hold
    if (PHY_W < 1 || PHY_W > 32 || LVL_W < 1 || LVL_W > 16 || ADR_W < 8) begin : g_chk
        $error("nim_irq: unsupported parameter value");
    end

    nim_pkg::nim_state_s s_q;
    nim_pkg::nim_state_s s_d;

    logic acc;
    logic commit;
    logic hit_mask;
    logic hit_evt;
    logic hit_thr;
    logic hit_rsvd;
    logic [31:0] wm;
    logic [31:0] set;
    logic [31:0] clr;
    logic [31:0] grp;
    logic [31:0] phy_now;
    logic [1:0] tm_now;
    logic [LVL_W-1:0] thr_w;

    // Byte enables widened to a bit mask
    function automatic logic [31:0] sel_bits(input logic [3:0] sel);
        sel_bits = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : sel_bits

    // Word offset decode, low address bits only
    function automatic logic at_ofs(input logic [ADR_W-1:0] a, input logic [7:0] ofs);
        at_ofs = (a[7:0] == ofs);
    endfunction : at_ofs

    // Next state of the whole block
    always_comb begin
        s_d = s_q;
        acc = wb_cyc_i & wb_stb_i;
        // Access acts on the edge where the master sees ack
        commit = acc & s_q.ack;
        hit_mask = at_ofs(wb_adr_i, `NIM_OFS_MASK);
        hit_rsvd = at_ofs(wb_adr_i, `NIM_OFS_RSVD);
        hit_evt = at_ofs(wb_adr_i, `NIM_OFS_EVT);
        hit_thr = at_ofs(wb_adr_i, `NIM_OFS_THR);
        wm = sel_bits(wb_sel_i);
        thr_w = s_q.thr[LVL_W-1:0];

        // Registered ack, one cycle after the request is seen
        s_d.ack = acc & ~s_q.ack;
        if (acc & ~s_q.ack) begin
            if (hit_mask) begin
                s_d.dat = s_q.mask & `NIM_MASK_RW | s_q.mask & `NIM_MASK_GRP;
            end else if (hit_evt) begin
                s_d.dat = s_q.ev;
            end else if (hit_thr) begin
                s_d.dat = {16'h0000, s_q.thr};
            end else begin
                s_d.dat = 32'h00000000; // Reserved slot and holes read zero
            end
        end

        // Input synchronisers; the first stage feeds only the second
        s_d.up_s1 = user_input;
        s_d.up_s2 = s_q.up_s1;
        s_d.up_p = s_q.up_s2;
        phy_now = 32'h00000000;
        phy_now[PHY_W-1:0] = phy_status;
        s_d.phy_s1 = phy_now;
        s_d.phy_s2 = s_q.phy_s1;
        s_d.phy_p = s_q.phy_s2;
        // Armed once both sync stages and the history hold real samples
        s_d.phy_ok = {s_q.phy_ok[1:0], 1'b1};

        tm_now = {timer1_count == timer1_trigger, timer0_count == timer0_trigger};
        s_d.tm_p = tm_now;
        s_d.txc_busy = (tx_cmd_count != '0);
        s_d.txr_q = tx_fifo_rd;

        // Event sources
        set = 32'h00000000;
        set[`NIM_EV_RXF] = rx_frame_stored;
        set[`NIM_EV_RXD] = rx_xfer_done & rx_desc_irq_flag;
        set[`NIM_EV_PHY] = s_q.phy_ok[2] & (s_q.phy_s2 != s_q.phy_p);
        set[`NIM_EV_WAKE] = wake_frame_seen;
        set[`NIM_EV_UP0 +: 2] = s_q.up_s2 & ~s_q.up_p;
        set[`NIM_EV_TM0 +: 2] = tm_now & ~s_q.tm_p;
        set[`NIM_EV_TXE] = s_q.txc_busy & (tx_cmd_count == '0);
        // Level sampled the cycle after the read, once the FIFO count settled
        set[`NIM_EV_TXW] = s_q.txr_q & (tx_fifo_level == thr_w);

        // DMA-done request remembered across the frames of one command
        if (tx_frame_fetched) begin
            if (tx_frame_last) begin
                set[`NIM_EV_TXD] = s_q.dma_pend | dma_done_irq_request_flag;
                s_d.dma_pend = 1'b0;
            end else begin
                s_d.dma_pend = s_q.dma_pend | dma_done_irq_request_flag;
            end
        end

        // Clear on read of exactly what was returned, or write one to clear
        clr = 32'h00000000;
        if (commit & hit_evt) begin
            clr = wb_we_i ? (wb_dat_i & wm) : s_q.dat;
        end
        // A set in the clearing cycle wins, so no event is lost
        s_d.ev = ((s_q.ev & ~clr) | set) & `NIM_EVT_USED;

        // Mask register: plain bits, then the grouped set/clear bits
        grp = wb_dat_i & wm & `NIM_MASK_GRP;
        if (commit & wb_we_i & hit_mask) begin
            s_d.mask = (s_q.mask & ~(`NIM_MASK_RW & wm)) | (wb_dat_i & wm & `NIM_MASK_RW);
            if (wb_dat_i[`NIM_BIT_GSEL] & wm[`NIM_BIT_GSEL]) begin
                s_d.mask = s_d.mask | grp;
            end else begin
                s_d.mask = s_d.mask & ~grp;
            end
        end
        if (commit & wb_we_i & hit_thr) begin
            s_d.thr = (s_q.thr & ~wm[15:0]) | (wb_dat_i[15:0] & wm[15:0]);
            s_d.thr = s_d.thr & 16'(({LVL_W{1'b1}}));
        end

        if (!nrst) begin
            s_d = '0;
            s_d.mask = `NIM_MASK_RST;
            s_d.ev = `NIM_EVT_RST;
            s_d.thr = `NIM_THR_RST;
        end
    end

    // Single state register; reset folded in above
    always_ff @(posedge clk_sys) begin
        s_q <= s_d;
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    // Level irq straight from flops, so enabling with a pending event fires at once
    assign irq = s_q.mask[`NIM_BIT_MEN] & (|(s_q.ev & s_q.mask & `NIM_EVT_USED));

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    a_rx_frame_set: assert property (rx_frame_stored |=> s_q.ev[`NIM_EV_RXF])
        else $error("receive frame event not recorded");

    a_rx_frame_only: assert property ($rose(s_q.ev[`NIM_EV_RXF])
        |-> $past(rx_frame_stored))
        else $error("receive frame event without a stored frame");

    a_rx_desc_set: assert property (rx_xfer_done && rx_desc_irq_flag
        |=> s_q.ev[`NIM_EV_RXD])
        else $error("descriptor receive event not recorded");

    // Unflagged descriptors stay silent; only the frame event speaks for them
    a_rx_desc_flagless: assert property (rx_xfer_done && !rx_desc_irq_flag
        && !s_q.ev[`NIM_EV_RXD] |=> !s_q.ev[`NIM_EV_RXD])
        else $error("descriptor receive event without its flag");

    a_rx_desc_wait: assert property ($rose(s_q.ev[`NIM_EV_RXD])
        |-> $past(rx_xfer_done && rx_desc_irq_flag))
        else $error("descriptor receive event before transfer done");

    a_phy_change: assert property (s_q.phy_ok[2] && s_q.phy_s2 != s_q.phy_p
        |=> s_q.ev[`NIM_EV_PHY])
        else $error("phy status change missed");

    a_phy_quiet: assert property (!s_q.phy_ok[2] |=> !s_q.ev[`NIM_EV_PHY])
        else $error("phy event before the history was valid");

    a_wake_set: assert property (wake_frame_seen |=> s_q.ev[`NIM_EV_WAKE])
        else $error("wake frame event missed");

    a_wake_only: assert property ($rose(s_q.ev[`NIM_EV_WAKE])
        |-> $past(wake_frame_seen))
        else $error("wake frame event without a frame");

    a_gsel_reads_zero: assert property (wb_ack_o && hit_mask
        |-> !wb_dat_o[`NIM_BIT_GSEL])
        else $error("set/clear select bit read back");

    a_gsel_not_kept: assert property (!s_q.mask[`NIM_BIT_GSEL])
        else $error("set/clear select bit stored in the mask");

    a_group_write: assert property (commit && wb_we_i && hit_mask && wb_sel_i[2]
        |=> ((s_q.mask & `NIM_MASK_GRP & $past(grp))
        == ($past(wb_dat_i[`NIM_BIT_GSEL]) ? $past(grp) : 32'h00000000)))
        else $error("grouped mask write wrong");

    a_user_edge: assert property (s_q.up_s2[0] && !s_q.up_p[0]
        |=> s_q.ev[`NIM_EV_UP0])
        else $error("user input rising edge missed");

    a_user1_edge: assert property (s_q.up_s2[1] && !s_q.up_p[1]
        |=> s_q.ev[`NIM_EV_UP0+1])
        else $error("user input 1 rising edge missed");

    a_timer_match: assert property (timer1_count == timer1_trigger && !s_q.tm_p[1]
        |=> s_q.ev[`NIM_EV_TM0+1])
        else $error("timer 1 match missed");

    a_timer0_match: assert property (timer0_count == timer0_trigger && !s_q.tm_p[0]
        |=> s_q.ev[`NIM_EV_TM0])
        else $error("timer 0 match missed");

    a_evt_read_clear: assert property (commit && !wb_we_i && hit_evt
        && s_q.dat[`NIM_EV_TXE] && !set[`NIM_EV_TXE] |=> !s_q.ev[`NIM_EV_TXE])
        else $error("read did not clear queue empty event");

    a_evt_w1c: assert property (commit && wb_we_i && hit_evt && wb_sel_i[1]
        && wb_dat_i[`NIM_EV_RXF] && !set[`NIM_EV_RXF] |=> !s_q.ev[`NIM_EV_RXF])
        else $error("write one did not clear frame event");

    a_txe_cause: assert property ($rose(s_q.ev[`NIM_EV_TXE])
        |-> $past(s_q.txc_busy && tx_cmd_count == '0))
        else $error("queue empty event without prior non-zero count");

    a_txe_idle: assert property (!s_q.txc_busy && !s_q.ev[`NIM_EV_TXE]
        |=> !s_q.ev[`NIM_EV_TXE])
        else $error("queue empty event with no prior command");

    a_txw_level: assert property (s_q.txr_q && tx_fifo_level == thr_w
        |=> s_q.ev[`NIM_EV_TXW])
        else $error("transmit threshold event missed");

    a_txw_cause: assert property ($rose(s_q.ev[`NIM_EV_TXW])
        |-> $past(s_q.txr_q && tx_fifo_level == thr_w))
        else $error("threshold event without a read at the level");

    a_dma_last: assert property ($rose(s_q.ev[`NIM_EV_TXD])
        |-> $past(tx_frame_fetched && tx_frame_last))
        else $error("dma done event not on last frame");

    a_dma_pend: assert property (tx_frame_fetched && !tx_frame_last
        && dma_done_irq_request_flag ##1 (!tx_frame_fetched)[*2]
        |-> !set[`NIM_EV_TXD] && s_q.dma_pend)
        else $error("dma done request not held for last frame");

    a_dma_not_early: assert property (tx_frame_fetched && !tx_frame_last
        && !s_q.ev[`NIM_EV_TXD] |=> !s_q.ev[`NIM_EV_TXD])
        else $error("dma done event before the last frame");

    a_master_gate: assert property (!s_q.mask[`NIM_BIT_MEN] |-> !irq)
        else $error("irq without master enable");

    // Level output must follow the pending set, not only stay quiet when disabled
    a_irq_level: assert property (s_q.mask[`NIM_BIT_MEN]
        && |(s_q.ev & s_q.mask & `NIM_EVT_USED) |-> irq)
        else $error("irq missing with enabled pending event");

    a_event_kept: assert property (!s_q.mask[`NIM_BIT_MEN] && rx_frame_stored
        |=> s_q.ev[`NIM_EV_RXF])
        else $error("event dropped while master enable clear");

    a_evt_held: assert property (s_q.ev[`NIM_EV_RXF] && !(commit && hit_evt)
        |=> s_q.ev[`NIM_EV_RXF])
        else $error("event bit lost without a clear");

    a_enable_now: assert property ($rose(s_q.mask[`NIM_BIT_MEN])
        && |(s_q.ev & s_q.mask & `NIM_EVT_USED) |-> irq)
        else $error("pending event not raised on enable");

endmodule : nim_irq

// >>> bench/nim_irq_tb.sv
// Self-checking bench of the interrupt mask and event status block.
// Assumes nim_irq with default widths, reached over classic Wishbone.
`include "nim_defs.svh"

module nim_irq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, cyc, stb, we, ack, irq;
    logic [7:0] adr, phy, cmd_cnt;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, rd;
    logic rx_fs, rx_xd, rx_fl, wake, tx_rd, tx_ff, tx_last, tx_dfl;
    logic [1:0] upin;
    logic [15:0] t0c, t0t, t1c, t1t, lvl;
    int n_fail, tests_run;
    // One row: event source and the status bit it must raise
    typedef struct packed {logic [3:0] src; logic [31:0] ev;} nim_row_s;
    nim_row_s rows [11] = '{'{4'h0, 32'h00000800}, '{4'h1, 32'h00001000},
        '{4'h2, 32'h00004000}, '{4'h3, 32'h00020000}, '{4'h4, 32'h00040000},
        '{4'h5, 32'h00080000}, '{4'h6, 32'h00100000}, '{4'h7, 32'h00002000},
        '{4'h8, 32'h00000002}, '{4'h9, 32'h00000004}, '{4'hA, 32'h00000008}};

    nim_irq nim_irq_i (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rx_frame_stored(rx_fs), .rx_xfer_done(rx_xd),
        .rx_desc_irq_flag(rx_fl), .phy_status(phy), .wake_frame_seen(wake),
        .user_input(upin), .timer0_count(t0c), .timer0_trigger(t0t),
        .timer1_count(t1c), .timer1_trigger(t1t), .tx_cmd_count(cmd_cnt),
        .tx_fifo_rd(tx_rd), .tx_fifo_level(lvl), .tx_frame_fetched(tx_ff),
        .tx_frame_last(tx_last), .dma_done_irq_request_flag(tx_dfl), .irq(irq));

    // 50 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    // One classic cycle; request held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (ack === 1'b1) break;
        end
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (i == 20) begin
            n_fail++;
            final_report();
        end
    endtask : wb

    // Pulse one event source, then let the sync chains settle
    task automatic fire(input logic [3:0] s);
        @(posedge clk_sys);
        case (s)
            4'h0: rx_fs <= 1'b1;
            4'h1: rx_xd <= 1'b1;
            4'h2: wake <= 1'b1;
            4'h3: upin[0] <= 1'b1;
            4'h4: upin[1] <= 1'b1;
            4'h5: t0c <= t0t;
            4'h6: t1c <= t1t;
            4'h7: phy <= ~phy;
            4'h8: cmd_cnt <= 8'h01;
            4'h9: tx_rd <= 1'b1;
            default: tx_ff <= 1'b1;
        endcase
        @(posedge clk_sys);
        {rx_fs, rx_xd, wake, tx_rd, tx_ff} <= 5'h00;
        {upin, cmd_cnt, t0c, t1c} <= 42'h0;
        repeat (5) @(posedge clk_sys);
    endtask : fire

    // Main sequence; trailing counts and user pins are cleared after each pulse, PHY pins and lvl are not
    initial begin
        {nrst, cyc, stb, we, adr, wdat, rx_fs, rx_xd, wake, tx_rd, tx_ff} = '0;
        {phy, cmd_cnt, upin, t0c, t1c} = '0;
        {rx_fl, tx_last, tx_dfl, sel} = 7'h7F;
        {t0t, t1t, lvl} = {16'h0007, 16'h0009, 16'h0005};
        {n_fail, tests_run} = '0;
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, `NIM_OFS_MASK, 0);
        chk(rd, `NIM_MASK_RST);
        wb(1'b0, `NIM_OFS_EVT, 0);
        chk(rd, `NIM_EVT_RST);
        wb(1'b1, `NIM_OFS_THR, 32'h5);
        wb(1'b1, `NIM_OFS_MASK, 32'h001F788E);
        wb(1'b0, `NIM_OFS_MASK, 0);
        chk(rd, 32'h001E788E);
        foreach (rows[i]) begin
            fire(rows[i].src);
            chk({31'h0, irq}, 32'h1);
            wb(1'b0, `NIM_OFS_EVT, 0);
            chk(rd, rows[i].ev);
            wb(1'b0, `NIM_OFS_EVT, 0);
            chk(rd, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        // Group select low clears, high with zero data leaves alone
        wb(1'b1, `NIM_OFS_MASK, 32'h0002788E);
        wb(1'b0, `NIM_OFS_MASK, 0);
        chk(rd, 32'h001C788E);
        wb(1'b1, `NIM_OFS_MASK, 32'h0001788E);
        wb(1'b0, `NIM_OFS_MASK, 0);
        chk(rd, 32'h001C788E);
        fire(4'h3);
        chk({31'h0, irq}, 32'h0);
        wb(1'b0, `NIM_OFS_EVT, 0);
        chk(rd, 32'h00020000);
        // Master enable off: event still latches, irq held back
        wb(1'b1, `NIM_OFS_MASK, 32'h0000780E);
        fire(4'h0);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, `NIM_OFS_MASK, 32'h0000788E);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, `NIM_OFS_EVT, 32'h00000800);
        @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        // Negative cases: no flag, not last, level off threshold
        rx_fl <= 1'b0;
        fire(4'h1);
        tx_last <= 1'b0;
        fire(4'hA);
        lvl <= 16'h0006;
        fire(4'h9);
        wb(1'b0, `NIM_OFS_EVT, 0);
        chk(rd, 32'h0);
        {tx_last, tx_dfl} <= 2'b10;
        fire(4'hA);
        wb(1'b0, `NIM_OFS_EVT, 0);
        chk(rd, 32'h00000008);
        // Reserved slot and an unmapped offset read as zero
        wb(1'b1, `NIM_OFS_RSVD, 32'hFFFFFFFF);
        wb(1'b0, `NIM_OFS_RSVD, 0);
        chk(rd, 32'h0);
        wb(1'b0, 8'h40, 0);
        chk(rd, 32'h0);
        // Second reset in mid-run
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        nrst <= 1'b1;
        wb(1'b0, `NIM_OFS_MASK, 0);
        chk(rd, `NIM_MASK_RST);
        chk({31'h0, irq}, 32'h0);
        // PHY pins sit high across this reset; no change event may follow
        wb(1'b0, `NIM_OFS_EVT, 0);
        chk(rd, 32'h0);
        final_report();
    end
endmodule : nim_irq_tb
